/* File: rtl/pac_engine.sv */
`timescale 1ns/1ps
`default_nettype none

module pac_engine import pac_pkg::*; #(
	parameter int PKT_MAX = PKT_MAX_DEF,
	parameter logic [7:0] NARROW_CYCLES = NARROW_CYCLES_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// request
	input wire logic start,
	input wire pac_mode_e mode,
	input wire pac_var_e variant,
	input wire logic dir_tx,
	input wire logic [127:0] key,
	input wire logic [4:0] mac_hdr_len,
	input wire logic [7:0] key_seq,
	// packet in
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic in_ready,
	// packet out
	output logic out_valid,
	output logic [7:0] out_data,
	output logic out_last,
	input wire logic out_ready,
	// result
	output logic done,
	output logic accept,
	output logic bad_mode,
	output logic [31:0] rx_frame_cnt,
	output logic [7:0] rx_key_seq
);

	localparam int AW = $clog2(PKT_MAX);

	logic [7:0] pkt_r [PKT_MAX];
	pac_state_e state_r;
	pac_mode_e mode_r;
	pac_var_e var_r;
	logic tx_r;
	logic [127:0] key_r;
	logic [4:0] hdr_r;
	logic [7:0] kseq_r;
	logic [7:0] len_r;
	logic ovf_r;
	logic in_ready_r;
	logic [7:0] pos_r;
	logic [7:0] ctr_r;
	logic [63:0] chain_r;
	logic wait_r;
	logic cstart_r;
	logic acc_r;
	logic [7:0] out_len_r;
	logic [7:0] emit_pos_r;
	logic out_valid_r;
	logic [7:0] out_data_r;
	logic out_last_r;
	logic done_r;
	logic accept_r;
	logic bad_mode_r;
	logic [31:0] tx_cnt_r;
	logic [31:0] rx_last_r;
	logic [31:0] rx_fc_r;
	logic [7:0] rx_kseq_r;
	logic core_done;
	logic [63:0] core_out;
	logic take_w;
	logic emit_end_w;
	logic len_ok_w;
	logic tag_ok_w;
	logic fresh_w;
	logic [7:0] bs_w;
	logic [7:0] tag_len_w;
	logic [7:0] pay_w;
	logic [7:0] msg_end_w;
	logic [7:0] enc_end_w;
	logic [7:0] lim_w;
	logic [8:0] min_w;
	logic [63:0] blk_w;
	logic [63:0] nonce_w;
	logic [63:0] cin_w;
	logic [63:0] tag_w;
	logic [63:0] rx_tag_w;
	logic [31:0] fc_rx_w;
	logic [7:0] kseq_rx_w;
	logic [31:0] tx_fc_w;
	logic [7:0] fc_off_w;

	// -----------------------------------------------------------------
	// derived lengths and packet views
	// -----------------------------------------------------------------
	assign take_w = in_valid && in_ready_r;
	assign bs_w = (var_r == narrow_cipher_variant) ? NARROW_BLK_BYTES : WIDE_BLK_BYTES;
	assign tag_len_w = mode_r[0] ? LONG_TAG_BYTES : SHORT_TAG_BYTES;
	assign pay_w = {3'b000, hdr_r} + AUX_BYTES;
	assign msg_end_w = tx_r ? len_r : len_r - tag_len_w;
	assign enc_end_w = msg_end_w + tag_len_w;
	assign min_w = {1'b0, pay_w} + (tx_r ? 9'h000 : {1'b0, tag_len_w});
	assign len_ok_w = !ovf_r && ({1'b0, len_r} >= min_w)
		&& (!tx_r || ({1'b0, len_r} + {1'b0, tag_len_w} <= 9'(PKT_MAX)));
	assign tag_w = mode_r[0] ? chain_r : {32'h0, chain_r[31:0]};
	assign tag_ok_w = (rx_tag_w == tag_w);
	assign fresh_w = (fc_rx_w > rx_last_r);
	assign tx_fc_w = tx_cnt_r + 32'h1;
	assign fc_off_w = len_r - {3'b000, hdr_r};
	assign kseq_rx_w = pkt_r[AW'({3'b000, hdr_r} + KEYSEQ_OFS)];
	// forward cipher only: counter mode reuses encryption for both directions
	assign cin_w = (state_r == ST_MAC) ? (chain_r ^ blk_w) : nonce_w;
	assign emit_end_w = (emit_pos_r >= out_len_r) && (!out_valid_r || out_ready);

	always_comb begin
		logic [8:0] idx;
		idx = 9'h000;
		unique case (state_r)
			ST_DEC: lim_w = len_r;
			ST_ENC: lim_w = enc_end_w;
			default: lim_w = msg_end_w;
		endcase
		blk_w = 64'h0;
		nonce_w = 64'h0;
		rx_tag_w = 64'h0;
		fc_rx_w = 32'h0;
		for (int i = 0; i < 8; i++) begin
			idx = {1'b0, pos_r} + 9'(i);
			if (8'(i) < bs_w && idx < {1'b0, lim_w}) begin
				blk_w[8*i +: 8] = pkt_r[idx[AW-1:0]];
			end
			if (8'(i) < bs_w - 8'h01 && 5'(i) < hdr_r) begin
				nonce_w[8*i +: 8] = pkt_r[i];
			end
			idx = {1'b0, msg_end_w} + 9'(i);
			if (8'(i) < tag_len_w) begin
				rx_tag_w[8*i +: 8] = pkt_r[idx[AW-1:0]];
			end
			idx = {4'h0, hdr_r} + 9'(i);
			if (8'(i) < FC_BYTES) begin
				fc_rx_w[8*(i%4) +: 8] = pkt_r[idx[AW-1:0]];
			end
		end
		nonce_w[8*(bs_w-8'h01) +: 8] = ctr_r;
	end

	// -----------------------------------------------------------------
	// request capture and loading
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r <= auth_mode_short_tag;
			var_r <= wide_cipher_variant;
			tx_r <= 1'b0;
			key_r <= 128'h0;
			hdr_r <= 5'h00;
			kseq_r <= 8'h00;
			len_r <= 8'h00;
			ovf_r <= 1'b0;
			in_ready_r <= 1'b0;
		end else if (state_r == ST_IDLE && start) begin
			mode_r <= mode;
			var_r <= variant;
			tx_r <= dir_tx;
			key_r <= key;
			hdr_r <= mac_hdr_len;
			kseq_r <= key_seq;
			len_r <= 8'h00;
			ovf_r <= 1'b0;
			in_ready_r <= !(variant == narrow_cipher_variant && mode[0]);
		end else if (take_w) begin
			if (len_r < 8'(PKT_MAX)) begin
				len_r <= len_r + 8'h01;
			end else begin
				ovf_r <= 1'b1;
			end
			if (in_last) begin
				in_ready_r <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// packet store: load, counter insertion, keystream, tag
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		logic [8:0] widx;
		widx = 9'h000;
		if (take_w && len_r < 8'(PKT_MAX)) begin
			if (tx_r && len_r >= {3'b000, hdr_r} && fc_off_w < FC_BYTES) begin
				pkt_r[len_r[AW-1:0]] <= tx_fc_w[8*fc_off_w[1:0] +: 8];
			end else if (tx_r && fc_off_w == KEYSEQ_OFS && len_r >= {3'b000, hdr_r}) begin
				pkt_r[len_r[AW-1:0]] <= kseq_r;
			end else begin
				pkt_r[len_r[AW-1:0]] <= in_data;
			end
		end
		for (int i = 0; i < 8; i++) begin
			widx = {1'b0, pos_r} + 9'(i);
			if (core_done && (state_r == ST_DEC || state_r == ST_ENC)
				&& 8'(i) < bs_w && widx < {1'b0, lim_w}) begin
				pkt_r[widx[AW-1:0]] <= pkt_r[widx[AW-1:0]] ^ core_out[8*i +: 8];
			end
			widx = {1'b0, msg_end_w} + 9'(i);
			if (state_r == ST_CHECK && tx_r && 8'(i) < tag_len_w) begin
				pkt_r[widx[AW-1:0]] <= tag_w[8*i +: 8];
			end
		end
	end

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_IDLE;
			pos_r <= 8'h00;
			ctr_r <= 8'h00;
			chain_r <= 64'h0;
			wait_r <= 1'b0;
			cstart_r <= 1'b0;
			acc_r <= 1'b0;
			out_len_r <= 8'h00;
		end else begin
			cstart_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					if (start) begin
						acc_r <= 1'b0;
						if (variant == narrow_cipher_variant && mode[0]) begin
							state_r <= ST_FIN;
						end else begin
							state_r <= ST_LOAD;
						end
					end
				end
				ST_LOAD: begin
					if (take_w && in_last) begin
						state_r <= ST_SIZE;
					end
				end
				ST_SIZE: begin
					chain_r <= 64'h0;
					ctr_r <= 8'h00;
					wait_r <= 1'b0;
					if (!len_ok_w) begin
						state_r <= ST_FIN;
					end else if (mode_r[1] && !tx_r) begin
						state_r <= ST_DEC;
						pos_r <= pay_w;
					end else begin
						state_r <= ST_MAC;
						pos_r <= 8'h00;
					end
				end
				ST_DEC, ST_MAC, ST_ENC: begin
					if (!wait_r) begin
						if (pos_r >= lim_w) begin
							if (state_r == ST_DEC) begin
								state_r <= ST_MAC;
								pos_r <= 8'h00;
							end else if (state_r == ST_MAC) begin
								state_r <= ST_CHECK;
							end else begin
								state_r <= ST_EMIT;
							end
						end else begin
							cstart_r <= 1'b1;
							wait_r <= 1'b1;
						end
					end else if (core_done) begin
						wait_r <= 1'b0;
						pos_r <= pos_r + bs_w;
						ctr_r <= ctr_r + 8'h01;
						if (state_r == ST_MAC) begin
							chain_r <= core_out;
						end
					end
				end
				ST_CHECK: begin
					pos_r <= pay_w;
					ctr_r <= 8'h00;
					if (tx_r) begin
						acc_r <= 1'b1;
						out_len_r <= enc_end_w;
						state_r <= mode_r[1] ? ST_ENC : ST_EMIT;
					end else begin
						acc_r <= tag_ok_w && fresh_w;
						out_len_r <= msg_end_w;
						state_r <= (tag_ok_w && fresh_w) ? ST_EMIT : ST_FIN;
					end
				end
				ST_EMIT: begin
					if (emit_end_w) begin
						state_r <= ST_FIN;
					end
				end
				ST_FIN: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	pac_xtea_core #(
		.NARROW_CYCLES(NARROW_CYCLES)
	) u_core (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(cstart_r),
		.variant(var_r),
		.key(key_r),
		.blk_in(cin_w),
		.busy(),
		.done(core_done),
		.blk_out(core_out)
	);

	// -----------------------------------------------------------------
	// output stream; discarded packets never leave the store
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			out_valid_r <= 1'b0;
			out_data_r <= 8'h00;
			out_last_r <= 1'b0;
			emit_pos_r <= 8'h00;
		end else if (state_r == ST_CHECK) begin
			emit_pos_r <= 8'h00;
		end else if (state_r == ST_EMIT && (!out_valid_r || out_ready)) begin
			if (emit_pos_r < out_len_r) begin
				out_valid_r <= 1'b1;
				out_data_r <= pkt_r[emit_pos_r[AW-1:0]];
				out_last_r <= (emit_pos_r + 8'h01 == out_len_r);
				emit_pos_r <= emit_pos_r + 8'h01;
			end else begin
				out_valid_r <= 1'b0;
				out_last_r <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// result and frame counters
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done_r <= 1'b0;
			accept_r <= 1'b0;
			bad_mode_r <= 1'b0;
		end else begin
			done_r <= (state_r == ST_FIN);
			if (state_r == ST_FIN) begin
				accept_r <= acc_r;
			end
			if (state_r == ST_IDLE && start) begin
				bad_mode_r <= (variant == narrow_cipher_variant && mode[0]);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_cnt_r <= 32'h0;
			rx_last_r <= 32'h0;
			rx_fc_r <= 32'h0;
			rx_kseq_r <= 8'h00;
		end else begin
			if (state_r == ST_FIN && tx_r && acc_r) begin
				tx_cnt_r <= tx_fc_w;
			end
			if (state_r == ST_CHECK && !tx_r) begin
				rx_fc_r <= fc_rx_w;
				rx_kseq_r <= kseq_rx_w;
				if (tag_ok_w && fresh_w) begin
					rx_last_r <= fc_rx_w;
				end
			end
		end
	end

	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data = out_data_r;
	assign out_last = out_last_r;
	assign done = done_r;
	assign accept = accept_r;
	assign bad_mode = bad_mode_r;
	assign rx_frame_cnt = rx_fc_r;
	assign rx_key_seq = rx_kseq_r;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	mode_reject_a: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == ST_IDLE && start && variant == narrow_cipher_variant && mode[0]
		|-> ##2 (done_r && !accept_r && bad_mode_r))
		else $error("long tag on narrow variant not rejected");

	done_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
		done_r |=> !done_r && state_r == ST_IDLE)
		else $error("done longer than one cycle");

	replay_guard_a: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == ST_CHECK && !tx_r && !fresh_w |=> !acc_r && state_r == ST_FIN)
		else $error("stale frame counter accepted");

	tag_match_a: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == ST_CHECK && !tx_r && !tag_ok_w |=> !acc_r ##1 (done_r && !accept_r))
		else $error("tag mismatch accepted");

	tx_count_a: assert property (@(posedge clk_sys) disable iff (rst)
		done_r && accept_r && tx_r |-> tx_cnt_r == $past(tx_cnt_r) + 32'h1)
		else $error("transmit counter not advanced by one");

	clear_header_a: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(state_r) && (state_r == ST_DEC || state_r == ST_ENC)
		|-> pos_r == pay_w && ctr_r == 8'h00)
		else $error("counter pass does not start at payload with zero count");

	short_tag_a: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == ST_CHECK && !mode_r[0] |-> tag_w[63:32] == 32'h0 && tag_w[31:0] == chain_r[31:0])
		else $error("short tag not the low half of the chain result");

	ready_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_ready_r |-> state_r == ST_LOAD)
		else $error("packet input open outside loading");

	tag_append_a: assert property (@(posedge clk_sys) disable iff (rst)
		out_valid_r && out_last_r && tx_r |-> emit_pos_r == out_len_r && out_len_r == enc_end_w)
		else $error("transmit packet does not end after its tag");

endmodule

`default_nettype wire

/* File: rtl/pac_pkg.sv */
`default_nettype none

package pac_pkg;

	// -----------------------------------------------------------------
	// cipher constants
	// -----------------------------------------------------------------
	localparam logic [31:0] WIDE_DELTA = 32'h9E3779B9;
	localparam logic [15:0] NARROW_DELTA = 16'h9E37;
	localparam logic [7:0] WIDE_CYCLES = 8'h20;
	localparam logic [7:0] NARROW_CYCLES_DEF = 8'h20;

	// -----------------------------------------------------------------
	// packet layout, in bytes
	// -----------------------------------------------------------------
	localparam logic [7:0] WIDE_BLK_BYTES = 8'h08;
	localparam logic [7:0] NARROW_BLK_BYTES = 8'h04;
	localparam logic [7:0] SHORT_TAG_BYTES = 8'h04;
	localparam logic [7:0] LONG_TAG_BYTES = 8'h08;
	localparam logic [7:0] FC_BYTES = 8'h04;
	localparam logic [7:0] KEYSEQ_OFS = 8'h04;
	localparam logic [7:0] AUX_BYTES = 8'h05;
	localparam int PKT_MAX_DEF = 128;

	// -----------------------------------------------------------------
	// enumerations
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		auth_mode_short_tag = 2'h0,
		auth_mode_long_tag = 2'h1,
		combined_mode_short_tag = 2'h2,
		combined_mode_long_tag = 2'h3
	} pac_mode_e;

	typedef enum logic {
		wide_cipher_variant = 1'b0,
		narrow_cipher_variant = 1'b1
	} pac_var_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_LOAD = 4'h1,
		ST_SIZE = 4'h3,
		ST_DEC = 4'h2,
		ST_MAC = 4'h6,
		ST_CHECK = 4'h7,
		ST_ENC = 4'h5,
		ST_EMIT = 4'h4,
		ST_FIN = 4'hC
	} pac_state_e;

endpackage

`default_nettype wire

/* File: rtl/pac_xtea_core.sv */
`timescale 1ns/1ps
`default_nettype none

module pac_xtea_core import pac_pkg::*; #(
	parameter logic [7:0] NARROW_CYCLES = NARROW_CYCLES_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// request
	input wire logic start,
	input wire pac_var_e variant,
	input wire logic [127:0] key,
	input wire logic [63:0] blk_in,
	// result
	output logic busy,
	output logic done,
	output logic [63:0] blk_out
);

	logic busy_r;
	logic done_r;
	logic narrow_r;
	logic [31:0] v0_r;
	logic [31:0] v1_r;
	logic [31:0] sum_r;
	logic [7:0] cnt_r;
	logic [127:0] key_r;
	logic [31:0] w0;
	logic [31:0] w1;
	logic [31:0] ws;
	logic [15:0] a0;
	logic [15:0] a1;
	logic [15:0] as;
	logic [15:0] t0;
	logic [15:0] t1;
	logic [31:0] u0;
	logic [31:0] u1;

	// -----------------------------------------------------------------
	// one cycle = two feistel half rounds, forward direction only
	// -----------------------------------------------------------------
	always_comb begin
		ws = sum_r + WIDE_DELTA;
		u0 = ((v1_r << 4) ^ (v1_r >> 5)) + v1_r;
		w0 = v0_r + (u0 ^ (sum_r + key_r[{sum_r[1:0], 5'd0} +: 32]));
		u1 = ((w0 << 4) ^ (w0 >> 5)) + w0;
		w1 = v1_r + (u1 ^ (ws + key_r[{ws[12:11], 5'd0} +: 32]));
		as = sum_r[15:0] + NARROW_DELTA;
		t0 = ((v1_r[15:0] << 4) ^ (v1_r[15:0] >> 5)) + v1_r[15:0];
		a0 = v0_r[15:0] + (t0 ^ (sum_r[15:0] + key_r[{sum_r[1:0], 4'd0} +: 16]));
		t1 = ((a0 << 4) ^ (a0 >> 5)) + a0;
		a1 = v1_r[15:0] + (t1 ^ (as + key_r[{as[12:11], 4'd0} +: 16]));
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			narrow_r <= 1'b0;
			v0_r <= 32'h0;
			v1_r <= 32'h0;
			sum_r <= 32'h0;
			cnt_r <= 8'h00;
			key_r <= 128'h0;
		end else begin
			done_r <= 1'b0;
			if (start && !busy_r) begin
				busy_r <= 1'b1;
				sum_r <= 32'h0;
				key_r <= key;
				narrow_r <= (variant == narrow_cipher_variant);
				if (variant == narrow_cipher_variant) begin
					v0_r <= {16'h0000, blk_in[15:0]};
					v1_r <= {16'h0000, blk_in[31:16]};
					cnt_r <= NARROW_CYCLES;
				end else begin
					v0_r <= blk_in[31:0];
					v1_r <= blk_in[63:32];
					cnt_r <= WIDE_CYCLES;
				end
			end else if (busy_r) begin
				v0_r <= narrow_r ? {16'h0000, a0} : w0;
				v1_r <= narrow_r ? {16'h0000, a1} : w1;
				sum_r <= narrow_r ? {16'h0000, as} : ws;
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end

	assign busy = busy_r;
	assign done = done_r;
	// narrow result packed into the low word so the chain and tag logic see a 32-bit block
	assign blk_out = narrow_r ? {32'h0, v1_r[15:0], v0_r[15:0]} : {v1_r, v0_r};

	core_latency_a: assert property (@(posedge clk_sys) disable iff (rst)
		start && !busy_r |-> ##[2:257] done_r)
		else $error("cipher result not delivered in time");

	narrow_width_a: assert property (@(posedge clk_sys) disable iff (rst)
		done_r && narrow_r |-> blk_out[63:32] == 32'h0 && blk_out[31:16] == $past(a1))
		else $error("narrow cipher result leaks into upper half");

endmodule

`default_nettype wire

/* File: dv/pac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pac_host_model (
	// clock
	input wire logic clk_sys,
	// packet source
	output logic in_valid,
	output logic [7:0] in_data,
	output logic in_last,
	input wire logic in_ready,
	// packet sink
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	output logic out_ready
);
	logic [7:0] got[$];
	logic stall;
	int last_at;

	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		in_last = 1'b0;
		out_ready = 1'b0;
		stall = 1'b0;
		last_at = 0;
	end

	// a stalling sink drops ready every other cycle to exercise the hold
	always @(negedge clk_sys) begin
		out_ready <= stall ? ~out_ready : 1'b1;
	end

	// first byte flagged last, counted from one; zero while none seen
	always @(posedge clk_sys) begin
		if (out_valid === 1'b1 && out_ready) begin
			got.push_back(out_data);
			if (out_last === 1'b1 && last_at == 0)
				last_at = got.size();
		end
	end

	// each byte held until taken; data inverted once released
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			in_valid = 1'b1;
			in_data = q[i];
			in_last = (i == q.size() - 1);
			do @(posedge clk_sys); while (in_ready !== 1'b1);
			@(negedge clk_sys);
		end
		in_valid = 1'b0;
		in_last = 1'b0;
		in_data = ~in_data;
	endtask
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top import pac_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	pac_mode_e mode = auth_mode_short_tag;
	pac_var_e variant = wide_cipher_variant;
	logic dir_tx = 1'b1;
	logic [127:0] key = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
	logic [4:0] mac_hdr_len = 5'h03;
	logic [7:0] key_seq = 8'h5A;
	wire logic in_valid, in_last, in_ready, out_valid, out_last, out_ready;
	wire logic [7:0] in_data, out_data;
	logic done, accept, bad_mode;
	logic [31:0] rx_frame_cnt;
	logic [7:0] rx_key_seq;
	int num_errors = 0;
	int comparisons = 0;
	logic [7:0] pkt[$];
	logic [7:0] exp_q[$];
	logic [7:0] ct[$];
	logic [63:0] tag;
	localparam logic [7:0] NARROW_N = 8'h08;

	always #5 clk_sys = ~clk_sys;

	pac_engine #(.PKT_MAX(128), .NARROW_CYCLES(NARROW_N)) u_pac_engine (.clk_sys(clk_sys),
		.rst(rst), .start(start), .mode(mode), .variant(variant), .dir_tx(dir_tx),
		.key(key), .mac_hdr_len(mac_hdr_len), .key_seq(key_seq), .in_valid(in_valid),
		.in_data(in_data), .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready), .done(done),
		.accept(accept), .bad_mode(bad_mode), .rx_frame_cnt(rx_frame_cnt),
		.rx_key_seq(rx_key_seq));

	pac_host_model u_pac_host_model (.clk_sys(clk_sys), .in_valid(in_valid),
		.in_data(in_data), .in_last(in_last), .in_ready(in_ready),
		.out_valid(out_valid), .out_data(out_data), .out_last(out_last),
		.out_ready(out_ready));

	// ---------------------------------------------------------------
	// reference models for both cipher variants
	// ---------------------------------------------------------------
	function automatic logic [63:0] xtea(input logic [63:0] b);
		logic [31:0] v0, v1, s;
		v0 = b[31:0];
		v1 = b[63:32];
		s = 32'h0;
		for (int i = 0; i < WIDE_CYCLES; i++) begin
			v0 += (((v1 << 4) ^ (v1 >> 5)) + v1) ^ (s + key[32 * s[1:0] +: 32]);
			s += WIDE_DELTA;
			v1 += (((v0 << 4) ^ (v0 >> 5)) + v0) ^ (s + key[32 * s[12:11] +: 32]);
		end
		return {v1, v0};
	endfunction

	function automatic logic [63:0] mac(input int n);
		logic [63:0] c, b;
		c = 64'h0;
		for (int i = 0; i < n; i += 8) begin
			b = 64'h0;
			for (int j = 0; j < 8 && i + j < n; j++)
				b[8 * j +: 8] = pkt[i + j];
			c = xtea(c ^ b);
		end
		return c;
	endfunction

	function automatic logic [31:0] xtea_n(input logic [31:0] b);
		logic [15:0] v0, v1, s;
		v0 = b[15:0];
		v1 = b[31:16];
		s = 16'h0;
		for (int i = 0; i < NARROW_N; i++) begin
			v0 += (((v1 << 4) ^ (v1 >> 5)) + v1) ^ (s + key[16 * s[1:0] +: 16]);
			s += NARROW_DELTA;
			v1 += (((v0 << 4) ^ (v0 >> 5)) + v0) ^ (s + key[16 * s[12:11] +: 16]);
		end
		return {v1, v0};
	endfunction

	function automatic logic [31:0] mac_n(input int n);
		logic [31:0] c, b;
		c = 32'h0;
		for (int i = 0; i < n; i += 4) begin
			b = 32'h0;
			for (int j = 0; j < 4 && i + j < n; j++)
				b[8 * j +: 8] = pkt[i + j];
			c = xtea_n(c ^ b);
		end
		return c;
	endfunction

	task automatic ctr(input int p);
		logic [63:0] ks;
		for (int j = 0; p + j < exp_q.size(); j++) begin
			if (j % 8 == 0)
				ks = xtea({8'(j / 8), 32'h0, exp_q[2], exp_q[1], exp_q[0]});
			exp_q[p + j] ^= ks[8 * (j % 8) +: 8];
		end
	endtask

	task automatic build(input logic [31:0] c);
		pkt = {8'h41, 8'h88, 8'h05, c[7:0], c[15:8], c[23:16], c[31:24], key_seq,
			8'h11, 8'h22, 8'h33};
	endtask

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			$display("wrong value %s expected %0h seen %0h", n, e, g);
			num_errors++;
		end
	endtask

	task automatic chk_out();
		chk("out count", exp_q.size(), u_pac_host_model.got.size());
		chk("out last", exp_q.size(), u_pac_host_model.last_at);
		foreach (exp_q[i])
			if (i < u_pac_host_model.got.size())
				chk("out byte", exp_q[i], u_pac_host_model.got[i]);
	endtask

	task automatic run(input pac_mode_e m, input pac_var_e v, input logic tx);
		int t;
		// a new request only after the cycle in which done was high
		repeat (2) @(negedge clk_sys);
		mode = m;
		variant = v;
		dir_tx = tx;
		start = 1'b1;
		u_pac_host_model.got.delete();
		u_pac_host_model.last_at = 0;
		@(negedge clk_sys);
		start = 1'b0;
		u_pac_host_model.send(pkt);
		t = 0;
		while (done !== 1'b1 && t < 5000) begin
			@(posedge clk_sys);
			#1;
			t++;
		end
		chk("done seen", 1, t < 5000);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_tx_auth();
		build(1);
		exp_q = pkt;
		tag = mac(11);
		for (int i = 0; i < 4; i++)
			exp_q.push_back(tag[8 * i +: 8]);
		run(auth_mode_short_tag, wide_cipher_variant, 1'b1);
		chk_out();
		chk("accept", 1, accept);
	endtask

	task automatic t_rx_auth();
		pkt = exp_q;
		exp_q = pkt[0:10];
		run(auth_mode_short_tag, wide_cipher_variant, 1'b0);
		chk_out();
		chk("accept", 1, accept);
		chk("rx counter", 1, rx_frame_cnt);
		chk("rx key seq", 8'h5A, rx_key_seq);
		exp_q.delete();
		run(auth_mode_short_tag, wide_cipher_variant, 1'b0);
		chk("replay", 0, accept);
		chk_out();
		pkt[3] = 8'h02;
		run(auth_mode_short_tag, wide_cipher_variant, 1'b0);
		chk("altered counter", 0, accept);
		chk_out();
	endtask

	task automatic t_ccm();
		build(2);
		exp_q = pkt;
		tag = mac(11);
		for (int i = 0; i < 8; i++)
			exp_q.push_back(tag[8 * i +: 8]);
		ctr(8);
		u_pac_host_model.stall = 1'b1;
		run(combined_mode_long_tag, wide_cipher_variant, 1'b1);
		u_pac_host_model.stall = 1'b0;
		chk_out();
		chk("accept", 1, accept);
		ct = exp_q;
		exp_q = pkt;
		pkt = ct;
		run(combined_mode_long_tag, wide_cipher_variant, 1'b0);
		chk_out();
		chk("accept", 1, accept);
		chk("rx counter", 2, rx_frame_cnt);
	endtask

	task automatic t_narrow();
		pac_mode_e lm[2];
		lm = '{auth_mode_long_tag, combined_mode_long_tag};
		foreach (lm[i]) begin
			pkt.delete();
			exp_q.delete();
			run(lm[i], narrow_cipher_variant, 1'b1);
			chk("bad mode", 1, bad_mode);
			chk("accept", 0, accept);
			chk_out();
		end
		build(3);
		exp_q = pkt;
		tag = {32'h0, mac_n(11)};
		for (int i = 0; i < 4; i++)
			exp_q.push_back(tag[8 * i +: 8]);
		run(auth_mode_short_tag, narrow_cipher_variant, 1'b1);
		chk("bad mode", 0, bad_mode);
		chk("accept", 1, accept);
		chk("out count", 15, u_pac_host_model.got.size());
		chk_out();
	endtask

	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		t_tx_auth();
		t_rx_auth();
		t_ccm();
		t_narrow();
		finish_test();
	end
endmodule

`default_nettype wire
